// [logic/gpt_pkg.sv]
package gpt_pkg;
    // ----------------------------------------
    // Widths and timer slots
    // ----------------------------------------
    localparam int TMR_W = 16;
    localparam int NUM_TMR = 5;
    localparam int T_AUX_LO = 0;
    localparam int T_CORE_A = 1;
    localparam int T_AUX_HI = 2;
    localparam int T_AUX_B = 3;
    localparam int T_CORE_B = 4;
    localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_MAX = 16'hFFFF;
    localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_ALL = 10'h3FF;
    localparam logic [3:0] PRE_A_BASE = 4'h3;
    localparam logic [3:0] PRE_B_BASE = 4'h2;
    // ----------------------------------------
    // Synchronised pin vector positions
    // ----------------------------------------
    localparam int PIN_W = 11;
    localparam int PIN_A_IN = 0;
    localparam int PIN_A_UD = 3;
    localparam int PIN_B_IN = 6;
    localparam int PIN_B_UD = 8;
    localparam int PIN_CAP = 10;
    // ----------------------------------------
    // Register indices (byte address = index * 4)
    // ----------------------------------------
    localparam logic [9:0] IDX_CTRL_A = 10'h000;
    localparam logic [9:0] IDX_CTRL_B = 10'h003;
    localparam logic [9:0] IDX_TMR = 10'h005;
    localparam logic [9:0] IDX_CAPTURE_RELOAD_REG = 10'h00A;
    localparam logic [9:0] IDX_STATUS = 10'h00B;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int F_SEL = 0;
    localparam int F_MODE = 3;
    localparam int F_CLK = 3;
    localparam int F_RUN = 5;
    localparam int F_DOWN = 6;
    localparam int F_EXTDIR = 7;
    localparam int F_EDGE = 8;
    localparam int F_FUNC = 10;
    localparam int F_RELOAD = 10;
    localparam int F_CAPEDGE = 10;
    localparam int F_TLCLK = 12;
    localparam int F_CAPSRC = 12;
    localparam int F_CLRCAP = 14;
    localparam int F_TL_A = 6;
    localparam int F_TL_B = 7;
    typedef enum logic [1:0] {
        MODE_TIMER = 2'b00, MODE_GATED = 2'b01, MODE_COUNTER = 2'b10, MODE_INCR = 2'b11
    } gpt_mode_t;
    typedef enum logic [1:0] {
        FUNC_OWN = 2'b00, FUNC_RELOAD = 2'b01, FUNC_CAPTURE = 2'b10
    } gpt_func_t;
    typedef enum logic [1:0] {
        CLK_PRESCALE = 2'b00, CLK_EXT = 2'b01, CLK_TOGGLE = 2'b10
    } gpt_clk_t;
endpackage

// [logic/gpt_tmr_if.sv]
`timescale 1ns/1ps
interface gpt_tmr_if;
    import gpt_pkg::*;
    logic step;
    logic down;
    logic load;
    logic [TMR_W-1:0] load_val;
    logic [TMR_W-1:0] cnt;
    logic wrap;
    modport ctl(output step, output down, output load, output load_val, input cnt, input wrap);
    modport tmr(input step, input down, input load, input load_val, output cnt, output wrap);
endinterface

// [logic/gpt_timer.sv]
`timescale 1ns/1ps
module gpt_timer import gpt_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_b_in,
    gpt_tmr_if.tmr tif
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } gpt_tmr_state_t;
    gpt_tmr_state_t q;
    gpt_tmr_state_t d;

    assign tif.cnt = q.cnt;
    // RULE19 - wrap at limit
    assign tif.wrap = tif.step & (tif.down ? (q.cnt == TMR_ZERO) : (q.cnt == TMR_MAX));

    always_comb begin
        d = q;
        if (tif.load) begin
            d.cnt = tif.load_val;
        end else if (tif.step) begin
            d.cnt = tif.down ? q.cnt - TMR_ONE : q.cnt + TMR_ONE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // gpt_timer

// [logic/gpt_prescaler.sv]
`timescale 1ns/1ps
module gpt_prescaler import gpt_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [2:0][2:0] sel_a_in,
    input wire logic [1:0][2:0] sel_b_in,
    output logic [2:0] tick_a_out,
    output logic [1:0] tick_b_out
);
    typedef struct packed {
        logic [PRE_W-1:0] cnt;
    } gpt_pre_state_t;
    gpt_pre_state_t q;
    gpt_pre_state_t d;

    function automatic logic is_tick(input logic [PRE_W-1:0] c, input logic [3:0] sh);
        is_tick = &(c | (PRE_ALL << sh));
    endfunction

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_a
            // RULE3 - divide 8 to 1024
            assign tick_a_out[g] = is_tick(q.cnt, {1'b0, sel_a_in[g]} + PRE_A_BASE);
        end
        for (g = 0; g < 2; g++) begin : g_b
            // RULE11 - divide 4 to 512
            assign tick_b_out[g] = is_tick(q.cnt, {1'b0, sel_b_in[g]} + PRE_B_BASE);
        end
    endgenerate

    always_comb begin
        d = q;
        d.cnt = q.cnt + 10'h001;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule // gpt_prescaler

// [logic/gpt_unit.sv]
// Operation
// RULE1 - each group A timer selects timer, gated, counter or quadrature mode
// RULE2 - timer mode counts up or down on the prescaled clock
// RULE3 - group A prescaler codes 0..7 divide by 8 up to 1024
// RULE4 - counter mode counts selected edges of the timer input pin
// RULE5 - gated mode counts prescaled ticks only while the gate is high
// RULE6 - quadrature mode derives count and direction from input and updown pins
// RULE7 - core A toggle latch flips on each wrap and drives its pin
// RULE8 - aux A timers may count core A toggle latch transitions
// RULE9 - aux A timers may act as reload source or capture target for core A
// RULE10 - group B holds two timers and the capture reload register
// RULE11 - group B prescaler codes 0..7 divide by 4 up to 512
// RULE12 - group B direction set by software, optionally flipped by updown pin
// RULE13 - core B toggle latch flips on wrap, clocks aux B, drives pin
// RULE14 - core B wrap clocks compare unit timers and reloads core B
// RULE15 - selected capture pin edge copies aux B into capture register
// RULE16 - aux B optionally cleared right after each capture
// RULE17 - capture may also be triggered by core A input or direction pin
// RULE18 - all five timers are 16 bits and may be chained in their group
// RULE19 - up count wraps max to zero, down count wraps zero to max
// RULE20 - each wrap and each capture sets a sticky request flag; aux A captures of core A set no flag here
`timescale 1ns/1ps
module gpt_unit import gpt_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] timer_input_pin_a_in,
    input wire logic [2:0] updown_pin_a_in,
    input wire logic [1:0] timer_input_pin_b_in,
    input wire logic [1:0] updown_pin_b_in,
    input wire logic capture_pin_in,
    output logic core_a_toggle_pin_out,
    output logic core_b_toggle_pin_out,
    output logic compare_unit_clk_out
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic [PIN_W-1:0] s3;
        logic [2:0][15:0] ca;
        logic [1:0][15:0] cb;
        logic [TMR_W-1:0] capture_reload_reg;
        logic [5:0] flag;
        logic tl_a;
        logic tl_b;
        logic cmp;
        logic [31:0] rdata;
        logic rdy;
        logic err;
    } gpt_state_t;
    gpt_state_t q;
    gpt_state_t d;

    logic [NUM_TMR-1:0] step;
    logic [NUM_TMR-1:0] down;
    logic [NUM_TMR-1:0] ld;
    logic [NUM_TMR-1:0][TMR_W-1:0] ldv;
    logic [NUM_TMR-1:0][TMR_W-1:0] cnt;
    logic [NUM_TMR-1:0] wrap;
    logic [2:0] tick_a;
    logic [1:0] tick_b;
    logic [2:0][2:0] sel_a;
    logic [1:0][2:0] sel_b;

    function automatic logic edge_hit(input logic r, input logic f, input logic [1:0] sel);
        edge_hit = (sel[0] & r) | (sel[1] & f);
    endfunction

    // ----------------------------------------
    // Prescaler and timers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sel_a
            assign sel_a[g] = q.ca[g][F_SEL+:3];
        end
        for (g = 0; g < 2; g++) begin : g_sel_b
            assign sel_b[g] = q.cb[g][F_SEL+:3];
        end
    endgenerate

    gpt_prescaler u_pre (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .sel_a_in(sel_a),
        .sel_b_in(sel_b),
        .tick_a_out(tick_a),
        .tick_b_out(tick_b)
    );

    gpt_tmr_if tif [NUM_TMR] ();
    generate
        for (g = 0; g < NUM_TMR; g++) begin : g_tmr
            assign tif[g].step = step[g];
            assign tif[g].down = down[g];
            assign tif[g].load = ld[g];
            assign tif[g].load_val = ldv[g];
            assign cnt[g] = tif[g].cnt;
            assign wrap[g] = tif[g].wrap;
            // RULE18 - 16-bit timer
            gpt_timer u_tmr (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .tif(tif[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic [PIN_W-1:0] rise;
    logic [PIN_W-1:0] fall;
    logic [PIN_W-1:0] lvl;
    logic [15:0] c;
    logic ea;
    logic eb;
    logic trig;
    logic acc;
    logic we;
    logic mapped;
    logic [9:0] idx;
    logic [31:0] rd;

    always_comb begin
        d = q;
        step = '0;
        down = '0;
        ld = '0;
        ldv = '0;
        c = CTRL_RST;
        ea = 1'b0;
        eb = 1'b0;
        // Two-stage pin synchroniser, third stage for edges
        d.s1 = {capture_pin_in, updown_pin_b_in, timer_input_pin_b_in, updown_pin_a_in, timer_input_pin_a_in};
        d.s2 = q.s1;
        d.s3 = q.s2;
        lvl = q.s2;
        rise = q.s2 & ~q.s3;
        fall = ~q.s2 & q.s3;

        // Group A timers
        for (int i = 0; i < 3; i++) begin
            c = q.ca[i];
            ea = rise[PIN_A_IN+i] | fall[PIN_A_IN+i];
            eb = rise[PIN_A_UD+i] | fall[PIN_A_UD+i];
            down[i] = c[F_DOWN] ^ (c[F_EXTDIR] & lvl[PIN_A_UD+i]);
            // RULE1 - mode select
            unique case (gpt_mode_t'(c[F_MODE+:2]))
                // RULE2 - prescaled count
                MODE_TIMER: begin
                    step[i] = tick_a[i];
                end
                // RULE5 - gate level
                MODE_GATED: begin
                    step[i] = tick_a[i] & lvl[PIN_A_IN+i];
                end
                // RULE4 - external edges
                MODE_COUNTER: begin
                    step[i] = edge_hit(rise[PIN_A_IN+i], fall[PIN_A_IN+i], c[F_EDGE+:2]);
                end
                // RULE6 - quadrature decode
                MODE_INCR: begin
                    step[i] = ea ^ eb;
                    down[i] = ea ? (lvl[PIN_A_IN+i] == lvl[PIN_A_UD+i])
                                 : (lvl[PIN_A_IN+i] != lvl[PIN_A_UD+i]);
                end
            endcase
            if (i != T_CORE_A) begin
                // RULE8 - chained to toggle latch
                if (c[F_TLCLK]) begin
                    step[i] = wrap[T_CORE_A];
                end
                // RULE9 - aux as capture register
                if (gpt_func_t'(c[F_FUNC+:2]) == FUNC_CAPTURE) begin
                    step[i] = 1'b0;
                    ld[i] = edge_hit(rise[PIN_A_IN+i], fall[PIN_A_IN+i], c[F_EDGE+:2]);
                    ldv[i] = cnt[T_CORE_A];
                end else if (gpt_func_t'(c[F_FUNC+:2]) == FUNC_RELOAD) begin
                    step[i] = 1'b0;
                end
            end
            step[i] = step[i] & c[F_RUN];
        end
        // RULE9 - aux as reload source
        if (wrap[T_CORE_A]) begin
            if (gpt_func_t'(q.ca[T_AUX_LO][F_FUNC+:2]) == FUNC_RELOAD) begin
                ld[T_CORE_A] = 1'b1;
                ldv[T_CORE_A] = cnt[T_AUX_LO];
            end else if (gpt_func_t'(q.ca[T_AUX_HI][F_FUNC+:2]) == FUNC_RELOAD) begin
                ld[T_CORE_A] = 1'b1;
                ldv[T_CORE_A] = cnt[T_AUX_HI];
            end
        end
        // RULE7 - core A toggle latch
        if (wrap[T_CORE_A]) begin
            d.tl_a = ~q.tl_a;
        end

        // Group B timers
        for (int j = 0; j < 2; j++) begin
            c = q.cb[j];
            // RULE12 - software and pin direction
            down[T_AUX_B+j] = c[F_DOWN] ^ (c[F_EXTDIR] & lvl[PIN_B_UD+j]);
            // RULE10 - clock source
            unique case (gpt_clk_t'(c[F_CLK+:2]))
                CLK_PRESCALE: step[T_AUX_B+j] = tick_b[j];
                CLK_EXT: step[T_AUX_B+j] = edge_hit(rise[PIN_B_IN+j], fall[PIN_B_IN+j], c[F_EDGE+:2]);
                // RULE13 - aux B on toggle latch
                CLK_TOGGLE: step[T_AUX_B+j] = (j == 0) & wrap[T_CORE_B];
                default: step[T_AUX_B+j] = 1'b0;
            endcase
            step[T_AUX_B+j] = step[T_AUX_B+j] & c[F_RUN];
        end
        // RULE13 - core B toggle latch
        if (wrap[T_CORE_B]) begin
            d.tl_b = ~q.tl_b;
        end
        // RULE14 - compare clock and reload
        d.cmp = wrap[T_CORE_B];
        if (wrap[T_CORE_B] & q.cb[1][F_RELOAD]) begin
            ld[T_CORE_B] = 1'b1;
            ldv[T_CORE_B] = q.capture_reload_reg;
        end
        c = q.cb[0];
        if (c[F_CAPSRC+:2] == 2'b00) begin
            // RULE15 - capture pin edge
            trig = edge_hit(rise[PIN_CAP], fall[PIN_CAP], c[F_CAPEDGE+:2]);
        end else begin
            // RULE17 - core A pin edges
            trig = (c[F_CAPSRC] & edge_hit(rise[PIN_A_IN+T_CORE_A], fall[PIN_A_IN+T_CORE_A], c[F_CAPEDGE+:2]))
                 | (c[F_CAPSRC+1] & edge_hit(rise[PIN_A_UD+T_CORE_A], fall[PIN_A_UD+T_CORE_A], c[F_CAPEDGE+:2]));
        end

        // APB slave
        acc = psel & penable;
        idx = paddr[11:2];
        mapped = (idx <= IDX_STATUS);
        we = acc & q.rdy & pwrite & mapped;
        d.rdy = acc & ~q.rdy;
        d.err = acc & ~q.rdy & ~mapped;
        rd = '0;
        if (idx < IDX_CTRL_B) begin
            rd[15:0] = q.ca[idx[1:0]];
        end else if (idx < IDX_TMR) begin
            rd[15:0] = q.cb[idx[1:0] - 2'h3];
        end else if (idx < IDX_CAPTURE_RELOAD_REG) begin
            rd[15:0] = cnt[3'(idx - IDX_TMR)];
        end else if (idx == IDX_CAPTURE_RELOAD_REG) begin
            rd[15:0] = q.capture_reload_reg;
        end else if (idx == IDX_STATUS) begin
            rd[5:0] = q.flag;
            rd[F_TL_A] = q.tl_a;
            rd[F_TL_B] = q.tl_b;
        end
        if (acc & ~q.rdy) begin
            d.rdata = rd;
        end
        if (we) begin
            if (idx < IDX_CTRL_B) begin
                d.ca[idx[1:0]] = pwdata[15:0];
            end else if (idx < IDX_TMR) begin
                d.cb[idx[1:0] - 2'h3] = pwdata[15:0];
            end else if (idx < IDX_CAPTURE_RELOAD_REG) begin
                ld[3'(idx - IDX_TMR)] = 1'b1;
                ldv[3'(idx - IDX_TMR)] = pwdata[15:0];
            end else if (idx == IDX_CAPTURE_RELOAD_REG) begin
                d.capture_reload_reg = pwdata[15:0];
            end else if (idx == IDX_STATUS) begin
                d.flag = q.flag & ~pwdata[5:0];
            end
        end
        if (trig) begin
            // RULE15 - capture aux B
            d.capture_reload_reg = cnt[T_AUX_B];
            // RULE16 - clear after capture
            if (c[F_CLRCAP]) begin
                ld[T_AUX_B] = 1'b1;
                ldv[T_AUX_B] = TMR_ZERO;
            end
        end
        // RULE20 - sticky flags, set wins
        d.flag = d.flag | {trig, wrap};
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = q.rdata;
    assign pready = q.rdy;
    assign pslverr = q.err;
    // RULE7 - latch drives pin
    assign core_a_toggle_pin_out = q.tl_a;
    // RULE13 - latch drives pin
    assign core_b_toggle_pin_out = q.tl_b;
    // RULE14 - compare unit clock
    assign compare_unit_clk_out = q.cmp;
endmodule // gpt_unit

// [tb/gpt_checker.sv]
`timescale 1ns/1ps
module gpt_checker import gpt_pkg::*; (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_a_toggle_pin_out,
    input wire logic core_b_toggle_pin_out,
    input wire logic compare_unit_clk_out
);
    // ----------------------------------------
    // Bus sequences
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_access;
        psel && $rose(penable);
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    AST_ACCESS_WAIT: assert property (s_access |-> !pready ##1 s_answer)
        else $error("access phase length wrong");
    AST_SLVERR_MAP: assert property (pready && paddr[11:2] > 10'd11 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_NO_ERR: assert property (pready && paddr[11:2] <= 10'd11 |-> !pslverr)
        else $error("mapped access refused");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    // ----------------------------------------
    // Toggle latches and compare clock
    // ----------------------------------------
    AST_STAT_TL_A: assert property (pready && !pwrite && paddr[11:2] == IDX_STATUS |-> prdata[6] == $past(core_a_toggle_pin_out))
        else $error("status latch A differs from pin");
    AST_STAT_TL_B: assert property (pready && !pwrite && paddr[11:2] == IDX_STATUS |-> prdata[7] == $past(core_b_toggle_pin_out))
        else $error("status latch B differs from pin");
    AST_CMP_PULSE: assert property (compare_unit_clk_out |=> !compare_unit_clk_out)
        else $error("compare clock longer than one cycle");
    AST_TL_B_CMP: assert property ($changed(core_b_toggle_pin_out) |-> ##[0:1] compare_unit_clk_out)
        else $error("latch B flip without compare clock");
endmodule // gpt_checker

bind gpt_unit gpt_checker u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_a_toggle_pin_out(core_a_toggle_pin_out), .core_b_toggle_pin_out(core_b_toggle_pin_out),
    .compare_unit_clk_out(compare_unit_clk_out));

// [tb/gpt_pin_model.sv]
`timescale 1ns/1ps
module gpt_pin_model (
    input wire logic clk_in,
    output logic [10:0] pins_out
);
    logic [1:0] ph;
    initial begin
        pins_out = 11'h000;
        ph = 2'b00;
    end
    task automatic pulse(input int i);
        @(posedge clk_in);
        pins_out[i] <= 1'b1;
        repeat (3) @(posedge clk_in);
        pins_out[i] <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    task automatic level(input int i, input logic v);
        @(posedge clk_in);
        pins_out[i] <= v;
    endtask
    task automatic quad(input logic dn, input int n);
        repeat (n) begin
            ph = dn ? ph - 2'd1 : ph + 2'd1;
            @(posedge clk_in);
            pins_out[1] <= ph[0] ^ ph[1];
            pins_out[4] <= ph[1];
            repeat (4) @(posedge clk_in);
        end
    endtask
endmodule // gpt_pin_model

// [tb/gpt_unit_bench.sv]
`timescale 1ns/1ps
module gpt_unit_bench;
    import gpt_pkg::*;
    logic clk_in, rst_b_in, psel, penable, pwrite, pready, pslverr, ev, tla, tlb, cmp, t0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [10:0] pins;
    int fails, compares, cyc, n;
    gpt_unit DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_input_pin_a_in(pins[2:0]), .updown_pin_a_in(pins[5:3]), .timer_input_pin_b_in(pins[7:6]),
        .updown_pin_b_in(pins[9:8]), .capture_pin_in(pins[10]), .core_a_toggle_pin_out(tla),
        .core_b_toggle_pin_out(tlb), .compare_unit_clk_out(cmp));
    gpt_pin_model PIN (.clk_in(clk_in), .pins_out(pins));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic stop_test();
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic delta(input logic [9:0] idx, input logic [15:0] exp);
        logic [15:0] v0;
        logic [15:0] d;
        apb(1'b0, idx, 32'h0);
        v0 = rv[15:0];
        repeat (1020) @(posedge clk_in);
        apb(1'b0, idx, 32'h0);
        d = rv[15:0] - v0;
        chk({16'h0000, d}, {16'h0000, exp});
    endtask
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {rst_b_in, psel, penable, pwrite, paddr, pwdata, fails, compares, cyc} = '0;
        repeat (4) @(posedge clk_in);
        rst_b_in <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, 10'(i), 32'h0);
            chk(rv, 32'h0);
        end
        apb(1'b0, 10'h00C, 32'h0);
        chk({31'h0, ev}, 32'h1);
        PIN.level(9, 1'b1);
        for (int g = 0; g < 2; g++) for (int s = 0; s < 8; s++) begin
            apb(1'b1, g ? IDX_CTRL_B + 10'h1 : IDX_CTRL_A + 10'h1, 32'(s) | 32'h20 | 32'((s & 3) << 6));
            delta(g ? IDX_TMR + 10'h4 : IDX_TMR + 10'h1,
                16'((((s ^ ((g * s) >> 1)) & 1) ? -1 : 1) * ((g ? 256 : 128) >> s)));
        end
        apb(1'b1, IDX_CTRL_B + 10'h1, 32'h0);
        apb(1'b1, IDX_CTRL_A, 32'h130);
        repeat (5) PIN.pulse(0);
        apb(1'b0, IDX_TMR, 32'h0);
        chk(rv, 32'h5);
        apb(1'b1, IDX_CTRL_A, 32'h330);
        repeat (3) PIN.pulse(0);
        apb(1'b0, IDX_TMR, 32'h0);
        chk(rv, 32'hB);
        apb(1'b1, IDX_CTRL_A + 10'h2, 32'h28);
        delta(IDX_TMR + 10'h2, 16'h0);
        PIN.level(2, 1'b1);
        repeat (4) @(posedge clk_in);
        delta(IDX_TMR + 10'h2, 16'h80);
        PIN.level(2, 1'b0);
        apb(1'b1, IDX_CTRL_A + 10'h1, 32'h338);
        apb(1'b1, IDX_TMR + 10'h1, 32'h0);
        PIN.quad(1'b0, 8);
        apb(1'b0, IDX_TMR + 10'h1, 32'h0);
        chk(rv, 32'h8);
        PIN.quad(1'b1, 3);
        apb(1'b0, IDX_TMR + 10'h1, 32'h0);
        chk(rv, 32'h5);
        apb(1'b1, IDX_CTRL_A + 10'h2, 32'h1020);
        apb(1'b1, IDX_TMR + 10'h2, 32'h0);
        apb(1'b1, IDX_STATUS, 32'h3F);
        apb(1'b1, IDX_TMR + 10'h1, 32'hFFFF);
        PIN.quad(1'b0, 1);
        apb(1'b0, IDX_TMR + 10'h1, 32'h0);
        chk(rv, 32'h0);
        chk({31'h0, tla}, 32'h1);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rv & 32'h7F, 32'h42);
        apb(1'b1, IDX_CTRL_A, 32'h400);
        apb(1'b1, IDX_TMR, 32'h1234);
        PIN.quad(1'b1, 1);
        apb(1'b0, IDX_TMR + 10'h1, 32'h0);
        chk(rv, 32'h1234);
        chk({31'h0, tla}, 32'h0);
        apb(1'b0, IDX_TMR + 10'h2, 32'h0);
        chk(rv, 32'h2);
        apb(1'b1, IDX_TMR + 10'h3, 32'hABC);
        apb(1'b1, IDX_CTRL_B, 32'h4400);
        PIN.pulse(10);
        apb(1'b0, IDX_CAPTURE_RELOAD_REG, 32'h0);
        chk(rv, 32'hABC);
        apb(1'b0, IDX_TMR + 10'h3, 32'h0);
        chk(rv, 32'h0);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rv & 32'h20, 32'h20);
        apb(1'b1, IDX_STATUS, 32'h20);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk(rv & 32'h20, 32'h0);
        apb(1'b1, IDX_TMR + 10'h3, 32'h55);
        apb(1'b1, IDX_CTRL_B, 32'h2400);
        apb(1'b1, IDX_CAPTURE_RELOAD_REG, 32'h0);
        PIN.pulse(4);
        apb(1'b0, IDX_CAPTURE_RELOAD_REG, 32'h0);
        chk(rv, 32'h55);
        apb(1'b0, IDX_TMR + 10'h3, 32'h0);
        chk(rv, 32'h55);
        apb(1'b1, IDX_CTRL_A, 32'h900);
        PIN.pulse(0);
        apb(1'b0, IDX_TMR, 32'h0);
        chk(rv, 32'h1234);
        apb(1'b1, IDX_CTRL_B, 32'h228);
        repeat (2) PIN.pulse(6);
        apb(1'b0, IDX_TMR + 10'h3, 32'h0);
        chk(rv, 32'h57);
        apb(1'b1, IDX_CAPTURE_RELOAD_REG, 32'hABC);
        apb(1'b1, IDX_TMR + 10'h3, 32'h0);
        apb(1'b1, IDX_CTRL_B, 32'h30);
        t0 = tlb;
        apb(1'b1, IDX_TMR + 10'h4, 32'hFFFF);
        apb(1'b1, IDX_CTRL_B + 10'h1, 32'h420);
        n = 0;
        while (cmp !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        chk({31'h0, n < 100}, 32'h1);
        @(negedge clk_in);
        chk({31'h0, tlb}, {31'h0, ~t0});
        apb(1'b0, IDX_TMR + 10'h3, 32'h0);
        chk(rv, 32'h1);
        apb(1'b0, IDX_TMR + 10'h4, 32'h0);
        chk({31'h0, rv - 32'hABC < 32'h4}, 32'h1);
        stop_test();
    end
endmodule // gpt_unit_bench
